//--- otp_host_model.sv
// Purpose: host serial controller model, mode 0, serial clock 400 ns
// Assumes: changes only at falling edges of clock_i
// Notes: released lanes carry a toggling pattern
`timescale 1ns/1ns
module otp_host_model (
	// clock
	input wire clock_i,
	// serial pins
	output reg serial_clock_o = 1'b0,
	output reg chip_select_n_o = 1'b1,
	output reg [3:0] serial_io_lane_o = 4'h0,
	input wire [3:0] serial_io_lane_i
);
	task half;
		repeat (4) @(negedge clock_i);
	endtask
	// one select period: opcode, then n read clocks
	task xfer(input [7:0] op, input quad, input integer n, output [31:0] rd);
		integer i;
		begin
			rd = 32'h0;
			@(negedge clock_i);
			chip_select_n_o = 1'b0;
			for (i = 0; i < (quad ? 2 : 8); i = i + 1) begin
				// upper lanes toggle in single mode
				serial_io_lane_o = quad ? (i == 0 ? op[7:4] : op[3:0]) : {~serial_io_lane_o[3:1], op[7-i]};
				half;
				serial_clock_o = 1'b1;
				half;
				serial_clock_o = 1'b0;
			end
			for (i = 0; i < n; i = i + 1) begin
				serial_io_lane_o = ~serial_io_lane_o;
				half;
				serial_clock_o = 1'b1;
				rd = quad ? {rd[27:0], serial_io_lane_i} : {rd[30:0], serial_io_lane_i[1]};
				half;
				serial_clock_o = 1'b0;
			end
			chip_select_n_o = 1'b1;
			repeat (12) @(negedge clock_i);
		end
	endtask
endmodule

//--- otp_map.vh
// Purpose: constants of the otp mode and security status slice
// Assumes: included by bare name
// Notes: opcodes and identity bytes are plain defaults
`ifndef OTP_MAP_VH
`define OTP_MAP_VH

// opcodes
`define OTP_OP_QUAD_IDENT 8'hAF
`define OTP_OP_ENTER 8'hB1
`define OTP_OP_EXIT 8'hC1
`define OTP_OP_READ_SECREG 8'h2B
`define OTP_OP_WRITE_SECREG 8'h2F

// security register field positions
`define OTP_SEC_FACTORY 0
`define OTP_SEC_LOCKDOWN 1
`define OTP_SEC_PGM_SUSP 2
`define OTP_SEC_ERS_SUSP 3
`define OTP_SEC_PGM_FAIL 5
`define OTP_SEC_ERS_FAIL 6
`define OTP_SEC_PROTECTION_SCHEME_SELECT 7

// reset values of volatile fields
`define OTP_SEC_VOLATILE_RST 1'b0
`define OTP_MODE_RST 1'b0

// identity bytes, values arbitrary
`define OTP_ID_MAKER 8'hA5
`define OTP_ID_TYPE 8'h5A
`define OTP_ID_DEVICE 8'h3C

// link timing
`define OTP_OPCODE_BITS 4'h8
`define OTP_SYNC_STAGES 2

`endif

//--- otp_secure_ctrl.v
// Purpose: otp mode entry and exit, quad identification read and security register read-out
// Assumes: serial clock, chip select and lanes are pins sampled on clock_i; reset is power-up
// Notes: non-volatile bits are sampled from nv_*_i on every cycle after reset release
`timescale 1ns/1ns
`include "otp_map.vh"

// Overview of operation
// - quad ident data starts on first falling serial clock edge, msb first, no dummies
// - ident sends maker, type, device bytes repeatedly until chip select rises
// - enter-otp selects the 4K-bit otp region and hides the main array
// - in otp mode ordinary read and program act on the otp region
// - write-status and write-secreg are refused while in otp mode
// - after lockdown only reads of the otp region are allowed
// - exit-otp returns reads and programs to the main array
// - opcodes arrive as 8 single-lane or 2 quad-lane clocks in one select
// - upper lanes are ignored while a single-lane opcode is received
// - security register read is served at any time, even during busy operations
// - security register byte repeats on serial out while select stays low
// - bit0 shows factory lock of the otp region, non-volatile
// - bit1 set by write-secreg or by nv_lockdown_i; once set, bit and region are frozen
// - bit2 and bit3 show program and erase suspend, volatile, reset zero
// - bit5 and bit6 set on program and erase failure, volatile, reset zero
// - bit7 selects protection scheme, one-time set, default zero
module otp_secure_ctrl #(
	parameter [7:0] ID_MAKER = `OTP_ID_MAKER,
	parameter [7:0] ID_TYPE = `OTP_ID_TYPE,
	parameter [7:0] ID_DEVICE = `OTP_ID_DEVICE
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// serial pins
	input wire serial_clock_i,
	input wire chip_select_n_i,
	input wire [3:0] serial_io_lane_i,
	output reg [3:0] serial_io_lane_o,
	output reg [3:0] serial_io_lane_oe_o,
	// core state from same-domain logic
	input wire quad_command_mode_i,
	input wire write_enable_latch_i,
	input wire program_suspended_i,
	input wire erase_suspended_i,
	input wire program_fail_i,
	input wire erase_fail_i,
	input wire fail_clear_i,
	input wire protection_scheme_select_set_i,
	input wire nv_factory_lock_i,
	input wire nv_lockdown_i,
	input wire nv_protection_scheme_select_i,
	// results to the core
	output reg otp_mode_o,
	output reg main_array_enable_o,
	output reg otp_program_allowed_o,
	output reg write_status_allowed_o,
	output reg lockdown_set_o,
	output reg [7:0] secreg_o,
	output reg cmd_valid_o,
	output reg [7:0] cmd_code_o
);

	localparam ST_OPCODE = 2'h0;
	localparam ST_SEND = 2'h1;
	localparam ST_IGNORE = 2'h2;

	wire sclk_s;
	wire cs_n_s;
	wire [3:0] lane_s;
	reg sclk_d_ff;
	reg cs_n_d_ff;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] op_ff;
	reg [7:0] nxt_op;
	reg [3:0] cnt_ff;
	reg [3:0] nxt_cnt;
	reg [23:0] out_ff;
	reg [23:0] nxt_out;
	reg quad_ff;
	reg factory_ff;
	reg lockdown_ff;
	reg protection_scheme_select_ff;
	reg pfail_ff;
	reg efail_ff;
	reg otp_ff;
	reg [7:0] secreg;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_rise;
	wire cs_fall;
	wire op_done;

	otp_sync #(
		.WIDTH(6),
		.RST_VAL(6'h20)
	) u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.async_i({chip_select_n_i, serial_clock_i, serial_io_lane_i}),
		.sync_o({cs_n_s, sclk_s, lane_s})
	);

	assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s;
	assign cs_rise = cs_n_s & ~cs_n_d_ff;
	assign cs_fall = ~cs_n_s & cs_n_d_ff;
	// opcode complete exactly at a byte boundary
	assign op_done = (state_ff == ST_SEND || state_ff == ST_IGNORE) && cnt_ff == `OTP_OPCODE_BITS;

	always @* begin
		secreg = 8'h00;
		secreg[`OTP_SEC_FACTORY] = factory_ff;
		secreg[`OTP_SEC_LOCKDOWN] = lockdown_ff;
		secreg[`OTP_SEC_PGM_SUSP] = program_suspended_i;
		secreg[`OTP_SEC_ERS_SUSP] = erase_suspended_i;
		secreg[`OTP_SEC_PGM_FAIL] = pfail_ff;
		secreg[`OTP_SEC_ERS_FAIL] = efail_ff;
		secreg[`OTP_SEC_PROTECTION_SCHEME_SELECT] = protection_scheme_select_ff;
	end

	// serial receive and transmit sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		if (cs_fall) begin
			nxt_state = ST_OPCODE;
			nxt_cnt = 4'h0;
			nxt_op = 8'h00;
		end else if (sclk_rise) begin
			case (state_ff)
				ST_OPCODE: begin
					if (quad_ff) begin
						nxt_op = {op_ff[3:0], lane_s};
						nxt_cnt = cnt_ff + 4'h4;
					end else begin
						nxt_op = {op_ff[6:0], lane_s[0]};
						nxt_cnt = cnt_ff + 4'h1;
					end
					if (nxt_cnt == `OTP_OPCODE_BITS) begin
						// no busy gating on the read path
						if (nxt_op == `OTP_OP_QUAD_IDENT && quad_ff) begin
							nxt_state = ST_SEND;
							nxt_out = {ID_MAKER, ID_TYPE, ID_DEVICE};
						end else if (nxt_op == `OTP_OP_READ_SECREG) begin
							nxt_state = ST_SEND;
							nxt_out = {secreg, secreg, secreg};
						end else begin
							nxt_state = ST_IGNORE;
						end
					end
				end
				ST_SEND: begin
					nxt_cnt = cnt_ff;
				end
				ST_IGNORE: begin
					// trailing bits break the byte boundary
					nxt_cnt = 4'hF;
				end
				default: begin
					nxt_state = ST_IGNORE;
				end
			endcase
		end else if (sclk_fall && state_ff == ST_SEND) begin
			// output flop takes the top unit now, so the next one moves up
			if (quad_ff) begin
				nxt_out = {out_ff[19:0], out_ff[23:20]};
			end else begin
				nxt_out = {out_ff[22:0], out_ff[23]};
			end
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			sclk_d_ff <= 1'b0;
			cs_n_d_ff <= 1'b1;
			state_ff <= ST_IGNORE;
			op_ff <= 8'h00;
			cnt_ff <= 4'h0;
			out_ff <= 24'h000000;
			quad_ff <= 1'b0;
			serial_io_lane_o <= 4'h0;
			serial_io_lane_oe_o <= 4'h0;
		end else begin
			sclk_d_ff <= sclk_s;
			cs_n_d_ff <= cs_n_s;
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
			if (cs_fall) begin
				quad_ff <= quad_command_mode_i;
			end
			if (cs_n_s || state_ff != ST_SEND) begin
				serial_io_lane_oe_o <= 4'h0;
			end else if (sclk_fall) begin
				// first falling edge after the opcode drives data at once
				if (quad_ff) begin
					serial_io_lane_o <= out_ff[23:20];
					serial_io_lane_oe_o <= 4'hF;
				end else begin
					serial_io_lane_o <= {2'b00, out_ff[23], 1'b0};
					serial_io_lane_oe_o <= 4'h2;
				end
			end
		end
	end

	// mode and security register state
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			otp_ff <= `OTP_MODE_RST;
			pfail_ff <= `OTP_SEC_VOLATILE_RST;
			efail_ff <= `OTP_SEC_VOLATILE_RST;
			factory_ff <= 1'b0;
			lockdown_ff <= 1'b0;
			protection_scheme_select_ff <= 1'b0;
			cmd_valid_o <= 1'b0;
			cmd_code_o <= 8'h00;
			lockdown_set_o <= 1'b0;
		end else begin
			cmd_valid_o <= 1'b0;
			lockdown_set_o <= 1'b0;
			// non-volatile image; lockdown and protection select never cleared once set, factory lock follows its input
			factory_ff <= nv_factory_lock_i;
			if (nv_lockdown_i) begin
				lockdown_ff <= 1'b1;
			end
			if (nv_protection_scheme_select_i || protection_scheme_select_set_i) begin
				protection_scheme_select_ff <= 1'b1;
			end
			// set wins over clear
			pfail_ff <= program_fail_i | (pfail_ff & ~fail_clear_i);
			efail_ff <= erase_fail_i | (efail_ff & ~fail_clear_i);
			if (cs_rise && op_done) begin
				cmd_valid_o <= 1'b1;
				cmd_code_o <= op_ff;
				if (op_ff == `OTP_OP_ENTER) begin
					otp_ff <= 1'b1;
				end else if (op_ff == `OTP_OP_EXIT) begin
					otp_ff <= 1'b0;
				end else if (op_ff == `OTP_OP_WRITE_SECREG && write_enable_latch_i && !otp_ff) begin
					// write enable latch must be set
					lockdown_ff <= 1'b1;
					lockdown_set_o <= ~lockdown_ff;
				end
			end
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			otp_mode_o <= `OTP_MODE_RST;
			main_array_enable_o <= 1'b1;
			otp_program_allowed_o <= 1'b0;
			write_status_allowed_o <= 1'b1;
			secreg_o <= 8'h00;
		end else begin
			otp_mode_o <= otp_ff;
			main_array_enable_o <= ~otp_ff;
			otp_program_allowed_o <= otp_ff & ~lockdown_ff & ~factory_ff;
			write_status_allowed_o <= ~otp_ff;
			secreg_o <= secreg;
		end
	end

endmodule

//--- otp_secure_ctrl_checker.sv
// Purpose: port-level checks of the otp mode and security status slice
// Assumes: one clock domain, synchronous active low reset
// Notes: bound to every otp_secure_ctrl instance
`timescale 1ns/1ns
module otp_secure_ctrl_checker (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// watched inputs
	input wire chip_select_n_i,
	input wire write_enable_latch_i,
	input wire program_suspended_i,
	input wire erase_suspended_i,
	input wire program_fail_i,
	// watched outputs
	input wire [3:0] serial_io_lane_oe_o,
	input wire otp_mode_o,
	input wire main_array_enable_o,
	input wire otp_program_allowed_o,
	input wire write_status_allowed_o,
	input wire lockdown_set_o,
	input wire [7:0] secreg_o,
	input wire cmd_valid_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_main_hidden: assert property ($stable(otp_mode_o)[*2] |-> main_array_enable_o == !otp_mode_o)
		else $error("main array enable not inverse of otp mode");
	a_wrstat_refused: assert property (otp_mode_o[*2] |-> !write_status_allowed_o)
		else $error("write status allowed in otp mode");
	a_otp_pgm_lock: assert property ((!otp_mode_o || secreg_o[1] || secreg_o[0])[*2]
		|-> !otp_program_allowed_o)
		else $error("otp program allowed while locked or outside otp mode");
	a_lock_sticky: assert property (secreg_o[1] |=> secreg_o[1])
		else $error("lockdown bit cleared");
	a_lock_cause: assert property (lockdown_set_o |-> (write_enable_latch_i && !otp_mode_o) ##[0:2] secreg_o[1])
		else $error("lockdown set without cause");
	a_protection_scheme_select_sticky: assert property (secreg_o[7] |=> secreg_o[7])
		else $error("protection select cleared");
	a_susp_live: assert property ($stable({erase_suspended_i, program_suspended_i})[*3]
		|-> secreg_o[3:2] == {erase_suspended_i, program_suspended_i})
		else $error("suspend flags not shown");
	a_pfail_set: assert property (program_fail_i |-> ##[1:2] secreg_o[5])
		else $error("program fail flag not set");
	a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
		else $error("command valid longer than one cycle");
	a_oe_release: assert property ($rose(chip_select_n_i) |-> ##[1:6] serial_io_lane_oe_o == 4'h0)
		else $error("lanes still driven after deselect");
endmodule
bind otp_secure_ctrl otp_secure_ctrl_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.chip_select_n_i(chip_select_n_i), .write_enable_latch_i(write_enable_latch_i),
	.program_suspended_i(program_suspended_i), .erase_suspended_i(erase_suspended_i),
	.program_fail_i(program_fail_i), .serial_io_lane_oe_o(serial_io_lane_oe_o), .otp_mode_o(otp_mode_o),
	.main_array_enable_o(main_array_enable_o), .otp_program_allowed_o(otp_program_allowed_o),
	.write_status_allowed_o(write_status_allowed_o), .lockdown_set_o(lockdown_set_o),
	.secreg_o(secreg_o), .cmd_valid_o(cmd_valid_o));

//--- otp_sync.v
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: one clock, synchronous active low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module otp_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// pins
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule

//--- testbench.sv
// Purpose: self-checking bench of the otp mode and security status slice
// Assumes: default opcodes and identity bytes
// Notes: host model runs the serial link
`timescale 1ns/1ns
`include "otp_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	reg clock_i = 0, rst_n_i = 0, quad = 0, wel = 0, psusp = 0, esusp = 0, pfail = 0, efail = 0;
	reg fclr = 0, wset = 0, nvf = 0, nvl = 0, nvw = 0;
	wire sclk, cs_n, otp_mode, main_en, pgm_ok, ws_ok, lock_set, cmd_valid;
	wire [3:0] host_o, dut_o, oe, lanes;
	wire [7:0] secreg, code;
	integer failures = 0, checked = 0, cycles = 0, cmds = 0, locks = 0;
	reg [31:0] rd;
	assign lanes = (oe & dut_o) | (~oe & host_o);
	initial forever #25 clock_i = ~clock_i;
	otp_secure_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clock_i(sclk), .chip_select_n_i(cs_n),
		.serial_io_lane_i(lanes), .serial_io_lane_o(dut_o), .serial_io_lane_oe_o(oe), .quad_command_mode_i(quad),
		.write_enable_latch_i(wel), .program_suspended_i(psusp), .erase_suspended_i(esusp),
		.program_fail_i(pfail), .erase_fail_i(efail), .fail_clear_i(fclr), .protection_scheme_select_set_i(wset),
		.nv_factory_lock_i(nvf), .nv_lockdown_i(nvl), .nv_protection_scheme_select_i(nvw), .otp_mode_o(otp_mode),
		.main_array_enable_o(main_en), .otp_program_allowed_o(pgm_ok), .write_status_allowed_o(ws_ok),
		.lockdown_set_o(lock_set), .secreg_o(secreg), .cmd_valid_o(cmd_valid), .cmd_code_o(code));
	otp_host_model u_host (.clock_i(clock_i), .serial_clock_o(sclk), .chip_select_n_o(cs_n),
		.serial_io_lane_o(host_o), .serial_io_lane_i(lanes));
	task give_verdict;
		begin
			if (failures == 0 && checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task run(input [7:0] op, input q, input integer n);
		begin
			@(negedge clock_i);
			quad = q;
			u_host.xfer(op, q, n, rd);
		end
	endtask
	// pulse counters, sampled where the pulses are settled
	always @(negedge clock_i) begin
		if (cmd_valid === 1'b1)
			cmds++;
		if (lock_set === 1'b1)
			locks++;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(negedge clock_i);
		rst_n_i = 1;
		repeat (4) @(negedge clock_i);
		`CHK(otp_mode, 1'b0)
		run(`OTP_OP_READ_SECREG, 0, 32);
		`CHK(rd, 32'h0)
		@(negedge clock_i);
		{psusp, pfail, efail, wset} = 4'hF;
		@(negedge clock_i);
		{pfail, efail, wset} = 3'h0;
		run(`OTP_OP_READ_SECREG, 1, 8);
		`CHK(rd, {4{8'hE4}})
		{fclr, psusp, esusp} = 3'h5;
		@(negedge clock_i);
		fclr = 0;
		run(`OTP_OP_READ_SECREG, 0, 32);
		`CHK(rd, {4{8'h88}})
		esusp = 0;
		run(`OTP_OP_QUAD_IDENT, 1, 8);
		`CHK(rd, ({`OTP_ID_MAKER, `OTP_ID_TYPE, `OTP_ID_DEVICE, `OTP_ID_MAKER}))
		`CHK(rd[31:24], `OTP_ID_MAKER)
		run(`OTP_OP_ENTER, 0, 0);
		`CHK(({otp_mode, main_en, pgm_ok, ws_ok}), 4'hA)
		`CHK(code, `OTP_OP_ENTER)
		`CHK(cmds, 5)
		wel = 1;
		run(`OTP_OP_WRITE_SECREG, 1, 0);
		`CHK(secreg[1], 1'b0)
		run(`OTP_OP_EXIT, 1, 0);
		`CHK(({otp_mode, main_en}), 2'h1)
		run(`OTP_OP_WRITE_SECREG, 0, 0);
		`CHK(secreg, 8'h82)
		`CHK(locks, 1)
		run(`OTP_OP_ENTER, 0, 0);
		`CHK(pgm_ok, 1'b0)
		@(negedge clock_i);
		{nvf, rst_n_i} = 2'h2;
		repeat (3) @(negedge clock_i);
		rst_n_i = 1;
		repeat (4) @(negedge clock_i);
		`CHK(({otp_mode, secreg[0]}), 2'h1)
		give_verdict;
	end
endmodule
